// ==== logic/csbh_bus_if.sv ====
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ns
`include "csbh_defs.svh"

module csbh_bus_if (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire csbh_pkg::csbh_word_t pwdata,
	output csbh_pkg::csbh_word_t prdata,
	output logic pready,
	output logic pslverr,
	input wire logic protocol_select_strap,
	input wire csbh_pkg::csbh_ratio_t clock_ratio_strap,
	input wire logic reference_clock_in,
	input wire csbh_pkg::csbh_word_t sys_addr_data_bus_in,
	output csbh_pkg::csbh_word_t sys_addr_data_bus_out,
	output logic sys_addr_data_bus_oe,
	input wire csbh_pkg::csbh_cmd_t sys_command_id_bus_in,
	output csbh_pkg::csbh_cmd_t sys_command_id_bus_out,
	output csbh_pkg::csbh_cmd_t sys_command_id_bus_oe,
	input wire csbh_pkg::csbh_chk_t sys_data_check_bus_in,
	output csbh_pkg::csbh_chk_t sys_data_check_bus_out,
	output csbh_pkg::csbh_chk_t sys_data_check_bus_oe,
	input wire logic command_parity_pin_in,
	output logic command_parity_pin_out,
	output logic command_parity_pin_oe,
	input wire logic agent_valid_in_n,
	output logic proc_valid_out_n,
	input wire logic agent_bus_request_n,
	output logic bus_handoff_n,
	input wire logic write_accept_n,
	input wire logic read_accept_n
);
	import csbh_pkg::*;

	logic proto_mode, cfg_ready, ratio_ok, agent_valid, agent_req, wr_acc;
	logic rd_acc, accept_ok, in_slave, slave_d, pend_q, dir_q, rx_valid_q;
	logic par_err_q, capture, wr_en, setup, rd_clear, err_clear, rd_hit;
	logic [3:0] hs_meta_q, hs_sync_q;
	csbh_ratio_t ratio_config_field;
	csbh_word_t ad_meta_q, ad_sync_q, tx_addr_q, tx_data_q, rx_data_q;
	csbh_word_t ad_out_d, rd_mux;
	csbh_cmd_t cmd_meta_q, cmd_sync_q, tx_acmd_q, tx_did_q, rx_cmd_q;
	csbh_cmd_t cmd_out_d;
	csbh_chk_t chk_meta_q, chk_sync_q, rx_chk_q, par_in, par_out;
	csbh_state_t state_q, state_d;

	csbh_strap_clk u_strap (
		.pclk(pclk),
		.presetn(presetn),
		.protocol_select_strap(protocol_select_strap),
		.clock_ratio_strap(clock_ratio_strap),
		.reference_clock_in(reference_clock_in),
		.proto_mode(proto_mode),
		.ratio_config_field(ratio_config_field),
		.cfg_ready(cfg_ready),
		.ratio_ok(ratio_ok)
	);

	////////////////////////////////////////////////////////////////////////
	// Every pin input but the parity pin passes two flops; bus words and their strobes share
	// the same latency so a word is always seen together with its valid.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ad_meta_q <= 32'h0;
			ad_sync_q <= 32'h0;
			cmd_meta_q <= 9'h0;
			cmd_sync_q <= 9'h0;
			chk_meta_q <= 4'h0;
			chk_sync_q <= 4'h0;
			hs_meta_q <= 4'hf;
			hs_sync_q <= 4'hf;
		end else begin
			ad_meta_q <= sys_addr_data_bus_in;
			ad_sync_q <= ad_meta_q;
			cmd_meta_q <= sys_command_id_bus_in;
			cmd_sync_q <= cmd_meta_q;
			chk_meta_q <= sys_data_check_bus_in;
			chk_sync_q <= chk_meta_q;
			hs_meta_q <= {agent_valid_in_n, agent_bus_request_n,
				write_accept_n, read_accept_n};
			hs_sync_q <= hs_meta_q;
		end
	end

	assign agent_valid = !hs_sync_q[3];
	assign agent_req = !hs_sync_q[2];
	assign wr_acc = !hs_sync_q[1];
	assign rd_acc = !hs_sync_q[0];
	// The shared accept pin acts for both directions in five-bit mode.
	assign accept_ok = proto_mode ? (dir_q ? wr_acc : rd_acc) : wr_acc;
	assign in_slave = (state_q == CSBH_RDWAIT) || (state_q == CSBH_SLAVE);
	for (genvar i = 0; i < 4; i++) begin : g_par
		assign par_in[i] = ^ad_sync_q[8*i +: 8];
		assign par_out[i] = ^ad_out_d[8*i +: 8];
	end

	////////////////////////////////////////////////////////////////////////
	// Registers are answered with no wait state; read data is caught in
	// the setup cycle so that prdata comes straight from a flop.
	assign pready = 1'b1;
	assign setup = psel && !penable;
	assign wr_en = psel && penable && pwrite;
	assign rd_clear = setup && !pwrite && (paddr == `CSBH_OFF_RXDATA);
	assign err_clear = wr_en && (paddr == `CSBH_OFF_STATUS)
		&& pwdata[`CSBH_ST_PARERR];
	always_comb begin
		rd_mux = 32'h0;
		rd_hit = 1'b1;
		case (paddr)
		`CSBH_OFF_CTRL: rd_mux[`CSBH_CTRL_WRITE] = dir_q;
		`CSBH_OFF_TXADDR: rd_mux = tx_addr_q;
		`CSBH_OFF_TXDATA: rd_mux = tx_data_q;
		`CSBH_OFF_TXCMD: begin
			rd_mux[8:0] = tx_acmd_q;
			rd_mux[`CSBH_TXCMD_DID_LSB +: 9] = tx_did_q;
		end
		`CSBH_OFF_STATUS: begin
			rd_mux[`CSBH_ST_BUSY] = pend_q;
			rd_mux[`CSBH_ST_OWNER] = !in_slave;
			rd_mux[`CSBH_ST_MODE] = proto_mode;
			rd_mux[`CSBH_ST_CFGOK] = cfg_ready;
			rd_mux[`CSBH_ST_EC_LSB +: 3] = ratio_config_field;
			rd_mux[`CSBH_ST_RATIO_OK] = ratio_ok;
			rd_mux[`CSBH_ST_RXVALID] = rx_valid_q;
			rd_mux[`CSBH_ST_PARERR] = par_err_q;
		end
		`CSBH_OFF_RXDATA: rd_mux = rx_data_q;
		`CSBH_OFF_RXCMD: begin
			rd_mux[8:0] = rx_cmd_q;
			rd_mux[`CSBH_RXCMD_CHK_LSB +: 4] = rx_chk_q;
		end
		default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata <= pwrite ? 32'h0 : rd_mux;
			pslverr <= !rd_hit;
		end
	end
	// Transfer set-up is locked while a transfer is pending.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dir_q <= 1'b0;
			tx_addr_q <= 32'h0;
			tx_data_q <= 32'h0;
			tx_acmd_q <= 9'h0;
			tx_did_q <= 9'h0;
		end else if (wr_en && !pend_q) begin
			case (paddr)
			`CSBH_OFF_CTRL: dir_q <= pwdata[`CSBH_CTRL_WRITE];
			`CSBH_OFF_TXADDR: tx_addr_q <= pwdata;
			`CSBH_OFF_TXDATA: tx_data_q <= pwdata;
			`CSBH_OFF_TXCMD: begin
				tx_acmd_q <= pwdata[8:0];
				tx_did_q <= pwdata[`CSBH_TXCMD_DID_LSB +: 9];
			end
			default: ;
			endcase
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_q <= 1'b0;
		end else if (wr_en && !pend_q && (paddr == `CSBH_OFF_CTRL)
			&& pwdata[`CSBH_CTRL_START]) begin
			pend_q <= 1'b1;
		end else if ((state_q == CSBH_WDATA)
			|| ((state_q == CSBH_RDWAIT) && agent_valid)) begin
			pend_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// An agent request wins over a pending transfer, which waits in idle.
	always_comb begin
		state_d = state_q;
		case (state_q)
		CSBH_IDLE: begin
			if (cfg_ready && agent_req) begin
				state_d = CSBH_SLAVE;
			end else if (cfg_ready && pend_q) begin
				state_d = CSBH_REQ;
			end
		end
		CSBH_REQ: if (accept_ok) state_d = CSBH_ADDR;
		CSBH_ADDR: state_d = dir_q ? CSBH_WDATA : CSBH_RDWAIT;
		CSBH_WDATA: state_d = CSBH_IDLE;
		CSBH_RDWAIT: if (agent_valid) state_d = CSBH_IDLE;
		CSBH_SLAVE: if (!agent_req && !agent_valid) state_d = CSBH_IDLE;
		default: state_d = CSBH_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= CSBH_IDLE;
		end else begin
			state_q <= state_d;
		end
	end
	assign capture = in_slave && agent_valid;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_data_q <= 32'h0;
			rx_cmd_q <= 9'h0;
			rx_chk_q <= 4'h0;
		end else if (capture) begin
			rx_data_q <= ad_sync_q;
			rx_cmd_q <= proto_mode ? cmd_sync_q
				: {4'h0, cmd_sync_q[4:0]};
			rx_chk_q <= proto_mode ? chk_sync_q : 4'h0;
		end
	end

	// A new word or parity fault wins over a clear in the same cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_valid_q <= 1'b0;
			par_err_q <= 1'b0;
		end else begin
			rx_valid_q <= capture || (rx_valid_q && !rd_clear);
			par_err_q <= (capture && proto_mode && (chk_sync_q != par_in))
				|| (par_err_q && !err_clear);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin outputs are built from the next state and registered, so each
	// pin changes on the same edge as the state it belongs to.
	always_comb begin
		slave_d = (state_d == CSBH_RDWAIT) || (state_d == CSBH_SLAVE);
		ad_out_d = (state_d == CSBH_WDATA) ? tx_data_q : tx_addr_q;
		cmd_out_d = (state_d == CSBH_WDATA) ? tx_did_q : tx_acmd_q;
		if (!proto_mode) begin
			cmd_out_d[8:5] = 4'h0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sys_addr_data_bus_out <= 32'h0;
			sys_command_id_bus_out <= 9'h0;
			sys_data_check_bus_out <= 4'h0;
			proc_valid_out_n <= 1'b1;
			bus_handoff_n <= 1'b1;
		end else begin
			sys_addr_data_bus_out <= ad_out_d;
			sys_command_id_bus_out <= cmd_out_d;
			sys_data_check_bus_out <= proto_mode ? par_out : 4'h0;
			proc_valid_out_n <= !((state_d == CSBH_ADDR)
				|| (state_d == CSBH_WDATA));
			if (!cfg_ready) begin
				bus_handoff_n <= 1'b1;
			end else if (proto_mode) begin
				bus_handoff_n <= !(slave_d && !in_slave);
			end else begin
				bus_handoff_n <= slave_d;
			end
		end
	end

	// In five-bit mode the unused lines are held low for the whole time,
	// which covers both address output and data input cycles.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sys_addr_data_bus_oe <= 1'b0;
			sys_command_id_bus_oe <= 9'h0;
			sys_data_check_bus_oe <= 4'h0;
			command_parity_pin_oe <= 1'b0;
		end else begin
			sys_addr_data_bus_oe <= cfg_ready && !slave_d;
			sys_command_id_bus_oe[4:0] <= {5{cfg_ready && !slave_d}};
			sys_command_id_bus_oe[8:5] <= {4{cfg_ready
				&& (!proto_mode || !slave_d)}};
			sys_data_check_bus_oe <= {4{cfg_ready
				&& (!proto_mode || !slave_d)}};
			command_parity_pin_oe <= cfg_ready
				&& (!proto_mode || !slave_d);
		end
	end

	// The parity pin carries no information; its input is never looked at.
	assign command_parity_pin_out = 1'b0;
	////////////////////////////////////////////////////////////////////////
	property p_addr_cycle;
		@(posedge pclk) disable iff (!presetn)
		state_q == CSBH_ADDR |-> !proc_valid_out_n && sys_addr_data_bus_oe
			&& sys_addr_data_bus_out == tx_addr_q;
	endproperty
	a_addr_cycle: assert property (p_addr_cycle)
		else $error("address cycle without valid address drive");
	property p_valid_drives;
		@(posedge pclk) disable iff (!presetn)
		!proc_valid_out_n |-> sys_addr_data_bus_oe
			&& (&sys_command_id_bus_oe[4:0]);
	endproperty
	a_valid_drives: assert property (p_valid_drives)
		else $error("valid output asserted while bus not driven");
	property p_slave_float;
		@(posedge pclk) disable iff (!presetn)
		in_slave |-> !sys_addr_data_bus_oe
			&& (sys_command_id_bus_oe[4:0] == 5'h0) && proc_valid_out_n;
	endproperty
	a_slave_float: assert property (p_slave_float)
		else $error("processor drives bus while agent owns it");
	property p_parity_low;
		@(posedge pclk) disable iff (!presetn)
		sys_addr_data_bus_oe |-> command_parity_pin_oe
			&& !command_parity_pin_out;
	endproperty
	a_parity_low: assert property (p_parity_low)
		else $error("parity pin not driven low with the bus");
	property p_five_tie;
		@(posedge pclk) disable iff (!presetn)
		cfg_ready && !proto_mode ##1 1'b1
			|-> (sys_data_check_bus_oe == 4'hf)
			&& (sys_data_check_bus_out == 4'h0)
			&& (sys_command_id_bus_oe[8:5] == 4'hf)
			&& (sys_command_id_bus_out[8:5] == 4'h0);
	endproperty
	a_five_tie: assert property (p_five_tie)
		else $error("unused lines not held low in five-bit mode");
	property p_check_par;
		@(posedge pclk) disable iff (!presetn)
		proto_mode && (state_q == CSBH_WDATA)
			|-> sys_data_check_bus_out[0] == ^sys_addr_data_bus_out[7:0]
			&& sys_data_check_bus_out[3] == ^sys_addr_data_bus_out[31:24];
	endproperty
	a_check_par: assert property (p_check_par)
		else $error("check bits do not match data word");
	property p_owner_level;
		@(posedge pclk) disable iff (!presetn)
		cfg_ready && !proto_mode ##1 cfg_ready
			|-> bus_handoff_n == in_slave;
	endproperty
	a_owner_level: assert property (p_owner_level)
		else $error("owner output does not follow bus mastership");
	property p_release_pulse;
		@(posedge pclk) disable iff (!presetn)
		proto_mode && $rose(in_slave) |-> !bus_handoff_n ##1 bus_handoff_n;
	endproperty
	a_release_pulse: assert property (p_release_pulse)
		else $error("release pulse missing on hand-over");
	property p_read_waits;
		@(posedge pclk) disable iff (!presetn)
		proto_mode && (state_q == CSBH_REQ) && !dir_q && !rd_acc
			|=> state_q == CSBH_REQ;
	endproperty
	a_read_waits: assert property (p_read_waits)
		else $error("read issued without read accept");
	property p_five_accept;
		@(posedge pclk) disable iff (!presetn)
		!proto_mode && (state_q == CSBH_REQ) && wr_acc
			|=> state_q == CSBH_ADDR;
	endproperty
	a_five_accept: assert property (p_five_accept)
		else $error("shared accept did not start the request");
endmodule // csbh_bus_if

// ==== logic/csbh_defs.svh ====
`ifndef CSBH_DEFS_SVH
`define CSBH_DEFS_SVH
// Overview of operation
// - Strap high picks the nine-bit command protocol, strap low the five-bit.
// - One shared 32-bit address/data bus, driven only by the cycle's source.
// - Nine-bit mode: each cycle carries a 9-bit command or data identifier.
// - Nine-bit mode: four check lines carry byte parity of data words.
// - Command parity pin is unused: driven low, input ignored.
// - Nine-bit mode: processor pulls valid-out low while driving a valid word.
// - Nine-bit mode: release output pulses low when the bus is handed over.
// - Five-bit mode: only the low five command lines carry codes.
// - Five-bit mode: upper command, check and parity lines driven low.
// - Five-bit mode: processor pulls its valid output low on valid words.
// - Five-bit mode: owner output stays low while the processor is master.
// - Five-bit mode: the read accept input is ignored.
// - A 3-bit ratio strap; code 000 gives field 010 and ratio 1:4.

`define CSBH_OFF_CTRL 8'h00
`define CSBH_OFF_TXADDR 8'h04
`define CSBH_OFF_TXDATA 8'h08
`define CSBH_OFF_TXCMD 8'h0c
`define CSBH_OFF_STATUS 8'h10
`define CSBH_OFF_RXDATA 8'h14
`define CSBH_OFF_RXCMD 8'h18

`define CSBH_CTRL_START 0
`define CSBH_CTRL_WRITE 1
`define CSBH_TXCMD_DID_LSB 16
`define CSBH_RXCMD_CHK_LSB 16

`define CSBH_ST_BUSY 0
`define CSBH_ST_OWNER 1
`define CSBH_ST_MODE 2
`define CSBH_ST_CFGOK 3
`define CSBH_ST_EC_LSB 4
`define CSBH_ST_RATIO_OK 7
`define CSBH_ST_RXVALID 8
`define CSBH_ST_PARERR 9

`define CSBH_STRAP_SETTLE 2'h2
`define CSBH_DIV_CODE_1_4 3'h0
`define CSBH_EC_1_4 3'h2
`define CSBH_EC_UNLISTED 3'h0
`define CSBH_REF_RATIO 4'h4
`endif

// ==== logic/csbh_pkg.sv ====
package csbh_pkg;
	typedef logic [31:0] csbh_word_t;
	typedef logic [8:0] csbh_cmd_t;
	typedef logic [3:0] csbh_chk_t;
	typedef logic [2:0] csbh_ratio_t;
	typedef enum logic [2:0] {
		CSBH_IDLE,
		CSBH_REQ,
		CSBH_ADDR,
		CSBH_WDATA,
		CSBH_RDWAIT,
		CSBH_SLAVE
	} csbh_state_t;
endpackage

// ==== logic/csbh_strap_clk.sv ====
`timescale 1ns/1ns
`include "csbh_defs.svh"

module csbh_strap_clk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic protocol_select_strap,
	input wire csbh_pkg::csbh_ratio_t clock_ratio_strap,
	input wire logic reference_clock_in,
	output logic proto_mode,
	output csbh_pkg::csbh_ratio_t ratio_config_field,
	output logic cfg_ready,
	output logic ratio_ok
);
	import csbh_pkg::*;

	logic [3:0] strap_meta_q;
	logic [3:0] strap_sync_q;
	logic [1:0] settle_q;
	csbh_ratio_t code_q;
	logic ref_meta_q;
	logic ref_sync_q;
	logic ref_prev_q;
	logic [3:0] cyc_q;

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_meta_q <= 4'h0;
			strap_sync_q <= 4'h0;
		end else begin
			strap_meta_q <= {protocol_select_strap, clock_ratio_strap};
			strap_sync_q <= strap_meta_q;
		end
	end

	// The straps are caught once the synchroniser has filled, then frozen.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			settle_q <= 2'h0;
			cfg_ready <= 1'b0;
			proto_mode <= 1'b0;
			code_q <= 3'h0;
			ratio_config_field <= 3'h0;
		end else if (!cfg_ready) begin
			if (settle_q == `CSBH_STRAP_SETTLE) begin
				cfg_ready <= 1'b1;
				proto_mode <= strap_sync_q[3];
				code_q <= strap_sync_q[2:0];
				if (strap_sync_q[2:0] == `CSBH_DIV_CODE_1_4) begin
					ratio_config_field <= `CSBH_EC_1_4;
				end else begin
					ratio_config_field <= `CSBH_EC_UNLISTED;
				end
			end else begin
				settle_q <= settle_q + 2'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// The core runs on pclk, so the ratio is checked by counting core
	// cycles per reference period rather than by synthesising a clock.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_meta_q <= 1'b0;
			ref_sync_q <= 1'b0;
			ref_prev_q <= 1'b0;
			cyc_q <= 4'h0;
			ratio_ok <= 1'b0;
		end else begin
			ref_meta_q <= reference_clock_in;
			ref_sync_q <= ref_meta_q;
			ref_prev_q <= ref_sync_q;
			if (ref_sync_q && !ref_prev_q) begin
				cyc_q <= 4'h0;
				ratio_ok <= cfg_ready && (code_q == `CSBH_DIV_CODE_1_4)
					&& (cyc_q == `CSBH_REF_RATIO - 4'h1);
			end else if (cyc_q != 4'hf) begin
				cyc_q <= cyc_q + 4'h1;
			end
		end
	end

	property p_ratio_map;
		@(posedge pclk) disable iff (!presetn)
		cfg_ready && (code_q == `CSBH_DIV_CODE_1_4)
			|-> ratio_config_field == `CSBH_EC_1_4;
	endproperty
	a_ratio_map: assert property (p_ratio_map)
		else $error("ratio code 000 did not give field 010");

	property p_strap_hold;
		@(posedge pclk) disable iff (!presetn)
		cfg_ready |=> cfg_ready && $stable(proto_mode)
			&& $stable(ratio_config_field);
	endproperty
	a_strap_hold: assert property (p_strap_hold)
		else $error("strap settings changed after capture");
endmodule // csbh_strap_clk

// ==== verification/csbh_agent.sv ====
`timescale 1ns/1ns

module csbh_agent (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic mode9,
	input wire logic stall,
	input wire logic bad_par,
	input wire logic own_req,
	input wire csbh_pkg::csbh_word_t rword,
	input wire csbh_pkg::csbh_cmd_t rid,
	input wire csbh_pkg::csbh_word_t bus_out,
	input wire logic bus_oe,
	input wire csbh_pkg::csbh_cmd_t cmd_out,
	input wire csbh_pkg::csbh_cmd_t cmd_oe,
	input wire csbh_pkg::csbh_chk_t chk_out,
	input wire csbh_pkg::csbh_chk_t chk_oe,
	output csbh_pkg::csbh_word_t bus_in,
	output csbh_pkg::csbh_cmd_t cmd_in,
	output csbh_pkg::csbh_chk_t chk_in,
	output logic par_in,
	output logic valid_n,
	output logic req_n,
	output logic wacc_n,
	output logic racc_n,
	output logic drv
);
	import csbh_pkg::*;
	logic oe_q;
	logic tog_q;
	logic drv_q;
	logic [1:0] cnt_q;
	function automatic csbh_chk_t par(input csbh_word_t w);
		return {^w[31:24], ^w[23:16], ^w[15:8], ^w[7:0]};
	endfunction
	// One reply word goes out three cycles after the processor lets go.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			oe_q <= 1'h0;
			tog_q <= 1'h0;
			drv_q <= 1'h0;
			cnt_q <= 2'h0;
		end else begin
			oe_q <= bus_oe;
			tog_q <= ~tog_q;
			drv_q <= (cnt_q == 2'h1);
			if (oe_q && !bus_oe)
				cnt_q <= 2'h2;
			else if (cnt_q != 2'h0)
				cnt_q <= cnt_q - 2'h1;
		end
	end
	// Lines nobody drives flip every cycle, so a stale value never passes.
	assign bus_in = drv_q ? rword : bus_oe ? bus_out : {32{tog_q}};
	assign cmd_in = drv_q ? (mode9 ? rid : {4'h0, rid[4:0]}) :
		(cmd_out & cmd_oe) | (~cmd_oe & {9{tog_q}});
	assign chk_in = (drv_q && mode9) ? par(rword) ^ {3'h0, bad_par} :
		(chk_out & chk_oe) | (~chk_oe & {4{tog_q}});
	assign par_in = tog_q;
	assign valid_n = ~drv_q;
	assign req_n = ~own_req;
	assign wacc_n = stall;
	// In five-bit mode this line runs against the real accept.
	assign racc_n = mode9 ? stall : ~stall;
	assign drv = drv_q;
endmodule // csbh_agent

// ==== verification/tb_cpu_system_bus_handshake.sv ====
`timescale 1ns/1ns
`include "csbh_defs.svh"

module tb_cpu_system_bus_handshake;
	import csbh_pkg::*;
	typedef struct {
		logic wr;
		csbh_word_t a;
		csbh_word_t d;
		csbh_cmd_t c;
		csbh_cmd_t i;
	} csbh_row_t;
	csbh_row_t rows[4] = '{
		'{1'h1, 32'h0000_1000, 32'h8421_00ff, 9'h1a5, 9'h0f3},
		'{1'h0, 32'hffff_fffc, 32'h1234_5678, 9'h0e1, 9'h11e},
		'{1'h1, 32'h0000_0000, 32'hffff_ffff, 9'h1ff, 9'h100},
		'{1'h0, 32'h7fff_0010, 32'h0000_0001, 9'h01f, 9'h1e0}};
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [7:0] paddr = 8'h00;
	csbh_word_t pwdata = 32'h0;
	logic mode_s = 1'h1;
	logic mode_m = 1'h1;
	csbh_ratio_t ratio_s = 3'h0;
	logic [1:0] refc = 2'h0;
	logic stall = 1'h0;
	logic bad_par = 1'h0;
	logic own_req = 1'h0;
	csbh_word_t rword = 32'h0;
	csbh_cmd_t rid = 9'h000;
	csbh_word_t prdata, bus_in, bus_out, rdata;
	csbh_cmd_t cmd_in, cmd_out, cmd_oe;
	csbh_chk_t chk_in, chk_out, chk_oe;
	logic pready, pslverr, bus_oe, par_in, par_out, par_oe, valid_n;
	logic valid_out_n, req_n, handoff_n, wacc_n, racc_n, drv, rerr;
	csbh_word_t qa[$], qc[$], qk[$];
	int err_count = 0;
	int samples_checked = 0;
	int hand_cnt = 0;

	always #5 pclk = ~pclk;
	always @(posedge pclk) refc <= refc + 2'h1;

	csbh_bus_if dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .protocol_select_strap(mode_s),
		.clock_ratio_strap(ratio_s), .reference_clock_in(refc[1]),
		.sys_addr_data_bus_in(bus_in), .sys_addr_data_bus_out(bus_out),
		.sys_addr_data_bus_oe(bus_oe), .sys_command_id_bus_in(cmd_in),
		.sys_command_id_bus_out(cmd_out), .sys_command_id_bus_oe(cmd_oe),
		.sys_data_check_bus_in(chk_in), .sys_data_check_bus_out(chk_out),
		.sys_data_check_bus_oe(chk_oe), .command_parity_pin_in(par_in),
		.command_parity_pin_out(par_out), .command_parity_pin_oe(par_oe),
		.agent_valid_in_n(valid_n), .proc_valid_out_n(valid_out_n),
		.agent_bus_request_n(req_n), .bus_handoff_n(handoff_n),
		.write_accept_n(wacc_n), .read_accept_n(racc_n));
	csbh_agent agent (.pclk, .presetn, .mode9(mode_m), .stall, .bad_par,
		.own_req, .rword, .rid, .bus_out, .bus_oe, .cmd_out, .cmd_oe, .chk_out,
		.chk_oe, .bus_in, .cmd_in, .chk_in, .par_in, .valid_n, .req_n,
		.wacc_n, .racc_n, .drv);

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input csbh_word_t seen, input csbh_word_t exp,
		input string what);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic final_report();
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input csbh_word_t d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do
			@(posedge pclk);
		while (pready !== 1'h1);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask

	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			apb(1'h0, `CSBH_OFF_STATUS, 32'h0);
			n++;
		end while (rdata[0] !== 1'h0 && n < 100);
		chk(rdata[0], 1'h0, "busy");
	endtask

	// Straps move away after capture, so a design that follows them shows.
	task automatic do_reset(input logic m, input csbh_ratio_t r);
		presetn <= 1'h0;
		mode_s <= m;
		mode_m <= m;
		ratio_s <= r;
		repeat (10) @(posedge pclk);
		chk(bus_oe, 1'h0, "reset_oe");
		chk(valid_out_n, 1'h1, "reset_valid");
		chk(handoff_n, 1'h1, "reset_handoff");
		presetn <= 1'h1;
		repeat (20) @(posedge pclk);
		apb(1'h0, `CSBH_OFF_STATUS, 32'h0);
		chk(rdata & 32'h3ff, {24'h0, r == 3'h0, (r == 3'h0) ? 3'h2 : 3'h0,
			1'h1, m, 2'h2}, "status");
		mode_s <= ~m;
		ratio_s <= 3'h7;
	endtask

	task automatic run_row(input csbh_row_t r);
		csbh_cmd_t m;
		int h;
		m = mode_m ? 9'h1ff : 9'h01f;
		h = hand_cnt;
		qa.delete();
		qc.delete();
		qk.delete();
		rword <= r.d;
		rid <= r.i;
		apb(1'h1, `CSBH_OFF_TXADDR, r.a);
		apb(1'h1, `CSBH_OFF_TXDATA, r.d);
		apb(1'h1, `CSBH_OFF_TXCMD, {7'h0, r.i, 7'h0, r.c});
		apb(1'h1, `CSBH_OFF_CTRL, {30'h0, r.wr, 1'h1});
		wait_idle();
		chk(32'(qa.size()), r.wr ? 32'h2 : 32'h1, "words");
		chk(qa[0], r.a, "addr");
		chk(qc[0], 32'(r.c & m), "acmd");
		chk(32'(hand_cnt - h), 32'(mode_m & !r.wr), "release");
		if (r.wr) begin
			chk(qa[1], r.d, "wdata");
			chk(qc[1], 32'(r.i & m), "wid");
			chk(qk[1], mode_m ? agent.par(r.d) : 4'h0, "wchk");
		end else begin
			apb(1'h0, `CSBH_OFF_STATUS, 32'h0);
			chk(rdata[9:8], 2'h1, "rx_flags");
			apb(1'h0, `CSBH_OFF_RXDATA, 32'h0);
			chk(rdata, r.d, "rdata");
			apb(1'h0, `CSBH_OFF_RXCMD, 32'h0);
			chk(rdata, {12'h0, mode_m ? agent.par(r.d) : 4'h0, 7'h0,
				r.i & m}, "rcmd");
		end
	endtask

	always @(posedge pclk) begin
		if (presetn) begin
			if (valid_out_n === 1'h0) begin
				qa.push_back(bus_out);
				qc.push_back(32'(cmd_out));
				qk.push_back(32'(chk_out));
				chk(bus_oe, 1'h1, "valid_oe");
			end
			if (mode_m && handoff_n === 1'h0)
				hand_cnt++;
			if (drv === 1'h1)
				chk(bus_oe, 1'h0, "contention");
			if (par_oe === 1'h1)
				chk(par_out, 1'h0, "parity_pin");
		end
	end

	initial begin
		repeat (20000) @(posedge pclk);
		err_count++;
		final_report();
	end

	initial begin
		do_reset(1'h1, 3'h0);
		foreach (rows[k])
			run_row(rows[k]);
		apb(1'h0, 8'h1c, 32'h0);
		chk(rerr, 1'h1, "unmapped_err");
		chk(rdata, 32'h0, "unmapped_data");
		// A flipped check bit must raise the parity error; writing one clears it.
		bad_par <= 1'h1;
		apb(1'h1, `CSBH_OFF_CTRL, 32'h1);
		wait_idle();
		apb(1'h0, `CSBH_OFF_STATUS, 32'h0);
		chk(rdata[9], 1'h1, "par_err");
		apb(1'h1, `CSBH_OFF_STATUS, 32'h200);
		apb(1'h0, `CSBH_OFF_STATUS, 32'h0);
		chk(rdata[9], 1'h0, "par_clear");
		bad_par <= 1'h0;
		do_reset(1'h0, 3'h5);
		foreach (rows[k])
			run_row(rows[k]);
		chk(handoff_n, 1'h0, "owner");
		// A slow agent holds the start; a TXADDR write while busy is dropped.
		stall <= 1'h1;
		qa.delete();
		apb(1'h1, `CSBH_OFF_TXADDR, 32'haaaa_0000);
		apb(1'h1, `CSBH_OFF_CTRL, 32'h1);
		apb(1'h1, `CSBH_OFF_TXADDR, 32'h5555_0000);
		repeat (20) @(posedge pclk);
		chk(32'(qa.size()), 32'h0, "stall_words");
		stall <= 1'h0;
		wait_idle();
		chk(qa[0], 32'haaaa_0000, "refused_addr");
		rword <= 32'h600d_0001;
		own_req <= 1'h1;
		repeat (10) @(posedge pclk);
		chk(handoff_n, 1'h1, "slave_owner");
		chk(bus_oe, 1'h0, "slave_oe");
		apb(1'h0, `CSBH_OFF_STATUS, 32'h0);
		chk(rdata[1], 1'h0, "slave_status");
		qa.delete();
		apb(1'h1, `CSBH_OFF_CTRL, 32'h3);
		repeat (10) @(posedge pclk);
		chk(32'(qa.size()), 32'h0, "slave_words");
		own_req <= 1'h0;
		wait_idle();
		chk(32'(qa.size()), 32'h2, "late_words");
		apb(1'h0, `CSBH_OFF_RXDATA, 32'h0);
		chk(rdata, 32'h600d_0001, "slave_rdata");
		final_report();
	end
endmodule // tb_cpu_system_bus_handshake
